// File: design/cstc_map.vh
// Purpose: constants for the self-test state control block
// Assumes: 50 MHz core clock
// Notes:   status codes other than the pass code are locally chosen
`ifndef CSTC_MAP_VH
`define CSTC_MAP_VH
`define CSTC_STATUS_W        8
`define CSTC_STATUS_PASS     8'h65
`define CSTC_STATUS_TEST     8'h01
`define CSTC_STATUS_ERROR    8'hee
`define CSTC_STATUS_ZERO     8'h0a
`define CSTC_STATUS_KEYLOAD  8'h0b
`define CSTC_PAGE_COUNT      6'h20
`define CSTC_PAGE_W          5
`define CSTC_PAGE_LAST       5'h1f
`define CSTC_USE_LIMIT       33'h100000000
`define CSTC_USE_W           33
`define CSTC_ST_RESET        3'h0
`define CSTC_ST_CHECK        3'h1
`define CSTC_ST_ZERO         3'h2
`define CSTC_ST_KEYLOAD      3'h3
`define CSTC_ST_OPER         3'h4
`define CSTC_ST_ERROR        3'h5
`define CSTC_VERSION         16'h0100
`define CSTC_IDENT           16'h1234
`endif

// File: design/cstc_selftest_ctrl.v
// Purpose: startup self-test, state and output gating control
// Assumes: check engine, page eraser and frame receivers are outside
// Notes:   version and identifier values are arbitrary
//
// Summary of operation
// [RULE1] startup runs only the engine known-answer check
// [RULE2] reset starts a fresh known-answer check
// [RULE3] pass without harness: operative, status 101
// [RULE4] data outputs inhibited before operative state
// [RULE5] failed check: error state, all outputs inhibited; command and request frame accepts stay live in error
// [RULE6] only reset leaves the error state
// [RULE7] data outputs off in key, test, zero, error
// [RULE8] incomplete command or request frames discarded
// [RULE9] zeroization erases exactly 32 key pages
// [RULE10] status never carries sensitive parameters
// [RULE11] each key used at most 2^32 times
// [RULE12] no secret parameters leave the device
// [RULE13] answer version and identifier requests
// [RULE14] pass with harness: zeroize, then key upload
// [RULE15] distinct status codes per non-operative state; reset and check states both show the test code 8'h01
`timescale 1ns/10ps
`include "cstc_map.vh"
module cstc_selftest_ctrl (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        known_answer_check_done_i,
  input  wire        known_answer_check_pass_i,
  input  wire        key_loading_serial_port_present_i,
  input  wire        page_erase_done_i,
  input  wire        key_upload_done_i,
  input  wire        command_frame_valid_i,
  input  wire        command_frame_complete_i,
  input  wire        telemetry_request_frame_valid_i,
  input  wire        telemetry_request_frame_complete_i,
  input  wire        version_request_i,
  input  wire        ident_request_i,
  input  wire        crypto_request_i,
  input  wire        key_select_i,
  output reg         known_answer_check_start_o,
  output reg         page_erase_start_o,
  output reg  [4:0]  page_erase_index_o,
  output reg         zeroize_done_o,
  output reg         data_out_enable_o,
  output reg         control_out_enable_o,
  output reg         crypto_grant_o,
  output reg         command_frame_accept_o,
  output reg         telemetry_request_frame_accept_o,
  output reg  [7:0]  status_code_o,
  output reg         info_valid_o,
  output reg  [15:0] info_data_o,
  output reg         key_uses_exhausted_o
);
// ==========================================================
// harness pin synchroniser
// harness may be plugged at any time, so one sample is never trusted
reg        harness_s1_reg;
reg        harness_s2_reg;
reg        harness_s3_reg;
reg        harness_reg;
always @(posedge core_clk_i) begin
  harness_s1_reg <= key_loading_serial_port_present_i;
  harness_s2_reg <= harness_s1_reg;
  harness_s3_reg <= harness_s2_reg;
  if (reset_i) begin
    harness_reg <= 1'b0;
  end else if (harness_s2_reg == harness_s3_reg) begin
    harness_reg <= harness_s3_reg;
  end
end
// ==========================================================
// state machine
reg [2:0]                state_reg;
reg [2:0]                state_next;
reg [`CSTC_PAGE_W-1:0]   page_reg;
reg                      erasing_reg;
reg [`CSTC_USE_W-1:0]    uses_reg;
wire oper = (state_reg == `CSTC_ST_OPER);
wire last_page = (page_reg == `CSTC_PAGE_LAST);
// ==========================================================
// next state
always @* begin
  state_next = state_reg;
  case (state_reg)
    `CSTC_ST_RESET: state_next = `CSTC_ST_CHECK; // RULE2
    `CSTC_ST_CHECK: begin
      if (known_answer_check_done_i) begin
        if (!known_answer_check_pass_i) begin
          state_next = `CSTC_ST_ERROR; // RULE5
        end else if (harness_reg) begin
          state_next = `CSTC_ST_ZERO; // RULE14
        end else begin
          state_next = `CSTC_ST_OPER; // RULE3
        end
      end
    end
    `CSTC_ST_ZERO: begin
      if (erasing_reg && page_erase_done_i && last_page) begin
        state_next = `CSTC_ST_KEYLOAD; // RULE14
      end
    end
    `CSTC_ST_KEYLOAD: state_next = `CSTC_ST_KEYLOAD;
    `CSTC_ST_OPER:    state_next = `CSTC_ST_OPER;
    `CSTC_ST_ERROR:   state_next = `CSTC_ST_ERROR; // RULE6
    default:          state_next = `CSTC_ST_ERROR;
  endcase
end
// key upload end is a power cycle, so keyload never exits on its own
always @(posedge core_clk_i) begin
  if (reset_i) begin
    state_reg   <= `CSTC_ST_RESET; // RULE2 RULE6
    page_reg    <= 5'h00;
    erasing_reg <= 1'b0;
  end else begin
    state_reg <= state_next;
    if (state_reg == `CSTC_ST_ZERO) begin
      if (!erasing_reg) begin
        erasing_reg <= 1'b1;
      end else if (page_erase_done_i) begin
        erasing_reg <= 1'b0;
        if (!last_page) begin
          page_reg <= page_reg + 5'h01; // RULE9
        end
      end
    end
  end
end
// ==========================================================
// key usage counter, cleared by a new key selection
// saturates at the limit, so a worn key stays refused until reselected
always @(posedge core_clk_i) begin
  if (reset_i || key_select_i) begin
    uses_reg <= 33'h000000000;
  end else if (oper && crypto_request_i && uses_reg < `CSTC_USE_LIMIT) begin
    uses_reg <= uses_reg + 33'h000000001; // RULE11
  end
end
// ==========================================================
// output next values
// levels follow state_next so they change in step with the status code
reg                      start_next;
reg                      erase_start_next;
reg                      zeroize_done_next;
reg                      data_enable_next;
reg                      control_enable_next;
reg                      grant_next;
reg                      exhausted_next;
reg                      command_accept_next;
reg                      request_accept_next;
reg [`CSTC_STATUS_W-1:0] status_next;
reg                      info_valid_next;
reg [15:0]               info_data_next;
wire                     limit_hit = (uses_reg >= `CSTC_USE_LIMIT);
always @* begin
  // one-shot start: the only startup test is the engine check
  start_next          = (state_reg == `CSTC_ST_RESET); // RULE1
  erase_start_next    = (state_reg == `CSTC_ST_ZERO) && !erasing_reg; // RULE9
  zeroize_done_next   = 1'b0;
  if ((state_next == `CSTC_ST_KEYLOAD) && (state_reg != `CSTC_ST_KEYLOAD)) begin
    zeroize_done_next = 1'b1; // RULE14
  end
  data_enable_next    = (state_next == `CSTC_ST_OPER); // RULE4 RULE7
  control_enable_next = (state_next != `CSTC_ST_ERROR) &&
                        (state_next != `CSTC_ST_RESET); // RULE5
  grant_next          = 1'b0;
  if (oper && crypto_request_i && !limit_hit) begin
    grant_next        = 1'b1; // RULE4 RULE5 RULE11
  end
  exhausted_next      = limit_hit; // RULE11
  command_accept_next = command_frame_valid_i && command_frame_complete_i; // RULE8
  request_accept_next = telemetry_request_frame_valid_i &&
                        telemetry_request_frame_complete_i; // RULE8
  // status holds only state codes, never key material
  case (state_next)
    `CSTC_ST_OPER:    status_next = `CSTC_STATUS_PASS; // RULE3 RULE10
    `CSTC_ST_ERROR:   status_next = `CSTC_STATUS_ERROR; // RULE15
    `CSTC_ST_ZERO:    status_next = `CSTC_STATUS_ZERO; // RULE15
    `CSTC_ST_KEYLOAD: status_next = `CSTC_STATUS_KEYLOAD; // RULE15
    default:          status_next = `CSTC_STATUS_TEST; // RULE15
  endcase
  info_valid_next = 1'b0;
  if (request_accept_next && (version_request_i || ident_request_i)) begin
    // error refuses even version and identifier answers
    info_valid_next = (state_next != `CSTC_ST_ERROR); // RULE13
  end
  // info port carries only version or identifier: keys never reach it
  if (version_request_i) begin
    info_data_next = `CSTC_VERSION; // RULE12 RULE13
  end else begin
    info_data_next = `CSTC_IDENT; // RULE12 RULE13
  end
end
// ==========================================================
// registered outputs
always @(posedge core_clk_i) begin
  if (reset_i) begin
    known_answer_check_start_o       <= 1'b0;
    page_erase_start_o               <= 1'b0;
    page_erase_index_o               <= 5'h00;
    zeroize_done_o                   <= 1'b0;
    data_out_enable_o                <= 1'b0;
    control_out_enable_o             <= 1'b0;
    crypto_grant_o                   <= 1'b0;
    command_frame_accept_o           <= 1'b0;
    telemetry_request_frame_accept_o <= 1'b0;
    status_code_o                    <= `CSTC_STATUS_TEST;
    info_valid_o                     <= 1'b0;
    info_data_o                      <= 16'h0000;
    key_uses_exhausted_o             <= 1'b0;
  end else begin
    known_answer_check_start_o       <= start_next;
    page_erase_start_o               <= erase_start_next;
    page_erase_index_o               <= page_reg;
    zeroize_done_o                   <= zeroize_done_next;
    data_out_enable_o                <= data_enable_next;
    control_out_enable_o             <= control_enable_next;
    crypto_grant_o                   <= grant_next;
    command_frame_accept_o           <= command_accept_next;
    telemetry_request_frame_accept_o <= request_accept_next;
    status_code_o                    <= status_next;
    info_valid_o                     <= info_valid_next;
    info_data_o                      <= info_data_next;
    key_uses_exhausted_o             <= exhausted_next;
  end
end
endmodule // cstc_selftest_ctrl

// File: verif/cstc_selftest_ctrl_asserts.sv
// Purpose: port checker for the self-test control
// Assumes: sync active-high reset
// Notes:   bound to every instance
`timescale 1ns/10ps
// ====
// checker
module cstc_chk (
  input wire       core_clk_i,
  input wire       reset_i,
  input wire       known_answer_check_done_i,
  input wire       known_answer_check_pass_i,
  input wire       key_loading_serial_port_present_i,
  input wire       command_frame_valid_i,
  input wire       command_frame_complete_i,
  input wire       known_answer_check_start_o,
  input wire       zeroize_done_o,
  input wire       data_out_enable_o,
  input wire       control_out_enable_o,
  input wire       crypto_grant_o,
  input wire       command_frame_accept_o,
  input wire [7:0] status_code_o,
  input wire       info_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_start; $fell(reset_i) |-> ##[0:1] known_answer_check_start_o; endproperty
  a_start: assert property (p_start) else $error("no check start after reset");
  property p_pass; status_code_o == 8'h01 && known_answer_check_done_i && known_answer_check_pass_i
    && !key_loading_serial_port_present_i |=> status_code_o == 8'h65 && data_out_enable_o; endproperty
  a_pass: assert property (p_pass) else $error("pass did not reach operative");
  property p_fail; status_code_o == 8'h01 && known_answer_check_done_i && !known_answer_check_pass_i
    |=> status_code_o == 8'hee; endproperty
  a_fail: assert property (p_fail) else $error("fail did not reach error");
  property p_err; status_code_o == 8'hee |-> !data_out_enable_o && !control_out_enable_o ##1 status_code_o == 8'hee;
  endproperty
  a_err: assert property (p_err) else $error("error state left or outputs live");
  property p_gate; data_out_enable_o |-> status_code_o == 8'h65; endproperty
  a_gate: assert property (p_gate) else $error("data out enabled outside operative");
  property p_grant; crypto_grant_o |-> $past(status_code_o) == 8'h65 && $past(data_out_enable_o); endproperty
  a_grant: assert property (p_grant) else $error("grant outside operative");
  property p_acc; command_frame_accept_o |-> $past(command_frame_valid_i) && $past(command_frame_complete_i);
  endproperty
  a_acc: assert property (p_acc) else $error("incomplete frame accepted");
  property p_zero; zeroize_done_o |-> ##[0:1] status_code_o == 8'h0b; endproperty
  a_zero: assert property (p_zero) else $error("no key load after zeroize");
  property p_info; info_valid_o |-> status_code_o != 8'hee; endproperty
  a_info: assert property (p_info) else $error("info answered in error");
endmodule // cstc_chk
bind cstc_selftest_ctrl cstc_chk cstc_chk_inst (.*);

// File: verif/cstc_far_model.sv
// Purpose: check engine and page eraser stand-in
// Assumes: start and erase are one-cycle pulses
// Notes:   result line inverted outside done
`timescale 1ns/10ps
// ====
// far side
module cstc_far_model (
  input  wire core_clk_i,
  input  wire start_i,
  input  wire erase_i,
  input  wire pass_sel_i,
  output reg  done_o,
  output reg  pass_o,
  output reg  erase_done_o
);
  reg [7:0] run_reg;
  reg [1:0] ers_reg;
  initial begin
    {run_reg, ers_reg, done_o, pass_o, erase_done_o} = 13'h0;
  end
  always @(posedge core_clk_i) begin
    run_reg      <= {run_reg[6:0], start_i};
    done_o       <= run_reg[7];
    pass_o       <= run_reg[7] ? pass_sel_i : !pass_sel_i;
    ers_reg      <= {ers_reg[0], erase_i};
    erase_done_o <= ers_reg[1];
  end
endmodule // cstc_far_model

// File: verif/tb_top.sv
// Purpose: self-checking bench for the self-test control
// Assumes: 50 MHz clock, inputs 2 ns after the edge
// Notes:   one task per scenario
`timescale 1ns/10ps
module tb_top;
  logic core_clk_i = 0, reset_i = 1, harness = 0, pass_sel = 1, cmd_v = 0, cmd_c = 0;
  logic tmr_v = 0, tmr_c = 0, ver_r = 0, id_r = 0, cry_r = 0, ksel = 0;
  wire kdone, kpass, edone, kstart, estart, zdone, den, cen, grant, cacc, tacc, ival, kex;
  wire [4:0] eidx;
  wire [7:0] st;
  wire [15:0] idat;
  int n_fail = 0, samples_checked = 0;
  always #10 core_clk_i = ~core_clk_i;
  cstc_selftest_ctrl cstc_selftest_ctrl_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .known_answer_check_done_i(kdone), .known_answer_check_pass_i(kpass), .key_loading_serial_port_present_i(harness),
    .page_erase_done_i(edone), .key_upload_done_i(1'b0), .command_frame_valid_i(cmd_v),
    .command_frame_complete_i(cmd_c), .telemetry_request_frame_valid_i(tmr_v),
    .telemetry_request_frame_complete_i(tmr_c), .version_request_i(ver_r), .ident_request_i(id_r),
    .crypto_request_i(cry_r), .key_select_i(ksel), .known_answer_check_start_o(kstart),
    .page_erase_start_o(estart), .page_erase_index_o(eidx), .zeroize_done_o(zdone), .data_out_enable_o(den),
    .control_out_enable_o(cen), .crypto_grant_o(grant), .command_frame_accept_o(cacc),
    .telemetry_request_frame_accept_o(tacc), .status_code_o(st), .info_valid_o(ival), .info_data_o(idat),
    .key_uses_exhausted_o(kex));
  cstc_far_model cstc_far_model_inst (.core_clk_i(core_clk_i), .start_i(kstart), .erase_i(estart),
    .pass_sel_i(pass_sel), .done_o(kdone), .pass_o(kpass), .erase_done_o(edone));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(int n); repeat (n) @(posedge core_clk_i); #2; endtask
  task automatic boot(logic p, logic h); pass_sel = p; harness = h; reset_i = 1; step(6); reset_i = 0; step(1);
  endtask
  task automatic wait_st(logic [7:0] c); for (int i = 0; i < 400 && st !== c; i++) step(1);
    chk("status", 16'(st), 16'(c));
  endtask
  task automatic t_pass;
    boot(1, 0);
    chk("den_check", 16'(den), 16'h0);
    wait_st(8'h65);
    chk("cen", 16'(cen), 16'h1);
    for (int k = 0; k < 2; k++) begin
      cmd_v = 1; cmd_c = k[0]; step(1); cmd_v = 0;
      chk("cmd_acc", 16'(cacc), 16'(k));
      tmr_v = 1; tmr_c = 1; ver_r = !k[0]; id_r = k[0]; step(1); tmr_v = 0;
      chk("tmr_acc", 16'(tacc), 16'h1);
      chk("info", ival ? idat : 16'h0, k ? 16'h1234 : 16'h0100);
    end
    tmr_v = 1; tmr_c = 0; step(1); tmr_v = 0;
    chk("tmr_part", 16'(tacc), 16'h0);
    ksel = 1; step(1); ksel = 0; cry_r = 1; step(1); cry_r = 0;
    chk("grant", 16'({grant, kex}), 16'h2);
  endtask
  task automatic t_harness;
    int pages = 0;
    boot(1, 1);
    for (int i = 0; i < 2000 && st !== 8'h0b; i++) begin
      if (estart === 1'b1) begin
        chk("page", 16'(eidx), 16'(pages));
        pages++;
      end
      step(1);
    end
    chk("pages", 16'(pages), 16'd32);
    chk("keyload", {7'h0, den, st}, 16'h000b);
    chk("zdone", 16'(zdone), 16'h1);
  endtask
  task automatic t_fail;
    boot(0, 0);
    wait_st(8'hee);
    cry_r = 1; step(1); cry_r = 0;
    chk("err_out", 16'({grant, den, cen}), 16'h0);
    step(20);
    chk("stuck", 16'(st), 16'h00ee);
    boot(1, 0);
    wait_st(8'h65);
  endtask
  task automatic complete_run;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bound well above the three scenarios
  initial begin #200000; n_fail++; complete_run(); end
  initial begin t_pass(); t_harness(); t_fail(); complete_run(); end
endmodule // tb_top
